// ---- dtd_consts.vh ----
`ifndef DTD_CONSTS_VH
`define DTD_CONSTS_VH

// ==========================================
// Opcodes
`define DTD_OP_LOAD_SEG 8'h8E
`define DTD_OP_STORE_SEG 8'h8C
`define DTD_OP_TRANSLATE 8'hD7
`define DTD_OP_LDEA 8'h8D
`define DTD_OP_LFP_DATA 8'hC5
`define DTD_OP_LFP_EXTRA 8'hC4
`define DTD_OP_FL2AH 8'h9F
`define DTD_OP_AH2FL 8'h9E

// ==========================================
// Operation codes on the output
`define DTD_K_NONE 4'h0
`define DTD_K_LOAD_SEG 4'h1
`define DTD_K_STORE_SEG 4'h2
`define DTD_K_TABLE 4'h3
`define DTD_K_LDEA 4'h4
`define DTD_K_LFP_DATA 4'h5
`define DTD_K_LFP_EXTRA 4'h6
`define DTD_K_FL2AH 4'h7
`define DTD_K_AH2FL 4'h8

// ==========================================
// Minimum cycle counts (wide / narrow)
`define DTD_C_LSEG_REG 7'h02
`define DTD_C_LSEG_MEM_W 7'h09
`define DTD_C_LSEG_MEM_N 7'h0D
`define DTD_C_SSEG_REG 7'h02
`define DTD_C_SSEG_MEM_W 7'h0B
`define DTD_C_SSEG_MEM_N 7'h0F
`define DTD_C_TABLE_W 7'h0B
`define DTD_C_TABLE_N 7'h0F
`define DTD_C_LDEA 7'h06
`define DTD_C_LFP_W 7'h12
`define DTD_C_LFP_N 7'h1A
`define DTD_C_FL2AH 7'h02
`define DTD_C_AH2FL 7'h03

// ==========================================
// Queue depths and addressing byte fields
`define DTD_Q_WIDE 4'h6
`define DTD_Q_NARROW 4'h4
`define DTD_MOD_REG 2'h3
`define DTD_MOD_HI 7
`define DTD_MOD_LO 6
`define DTD_REG_HI 5
`define DTD_REG_LO 3
`define DTD_RM_HI 2
`define DTD_RM_LO 0

`endif

// ---- dtd_decoder.v ----
`timescale 1ns/100ps
`include "dtd_consts.vh"

module dtd_decoder (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Variant strap: 1 = 16-bit bus interface unit, 0 = 8-bit
  input wire wideBus,
  // Prefetch queue head
  input wire [3:0] queueCount,
  input wire [7:0] queueByte0,
  input wire [7:0] queueByte1,
  // Execution unit handshake
  input wire execReady,
  // Decode result
  output reg decodeValid_r,
  output reg [3:0] opKind_r,
  output reg [6:0] minCycles_r,
  output reg memOperand_r,
  output reg wordSize_r,
  output reg [1:0] modField_r,
  output reg [2:0] regField_r,
  output reg [2:0] rmField_r,
  output reg illegalForm_r,
  output reg [1:0] consumeBytes_r,
  output reg decodeStall_r,
  output reg [3:0] queueDepth_r
);

  // ==========================================
  // Helpers

  // Pick register or memory figure, memory figure per bus variant
  function [6:0] pickCount;
    input isMem;
    input wide;
    input [6:0] regCnt;
    input [6:0] memWide;
    input [6:0] memNarrow;
    begin
      if (!isMem) begin
        pickCount = regCnt;
      end else if (wide) begin
        pickCount = memWide;
      end else begin
        pickCount = memNarrow;
      end
    end
  endfunction

  // Does this opcode carry an addressing byte
  function hasModrm;
    input [7:0] op;
    begin
      case (op)
        `DTD_OP_LOAD_SEG, `DTD_OP_STORE_SEG, `DTD_OP_LDEA,
        `DTD_OP_LFP_DATA, `DTD_OP_LFP_EXTRA: hasModrm = 1'b1;
        default: hasModrm = 1'b0;
      endcase
    end
  endfunction

  // ==========================================
  // Combinational decode
  reg [3:0] kindNxt;
  reg [6:0] cyclesNxt;
  reg illegalNxt;
  reg needsModrm;
  reg isMem;
  reg [3:0] bytesNeeded;
  reg haveBytes;

  always @* begin
    needsModrm = hasModrm(queueByte0);
    // Mode 11 is a register operand, all else touches memory
    isMem = (queueByte1[`DTD_MOD_HI:`DTD_MOD_LO] != `DTD_MOD_REG);
    if (needsModrm) begin
      bytesNeeded = 4'h2;
    end else begin
      bytesNeeded = 4'h1;
    end
    // Narrow variant often lacks bytes, so decode waits on the queue
    haveBytes = (queueCount >= bytesNeeded);
    kindNxt = `DTD_K_NONE;
    cyclesNxt = 7'h00;
    illegalNxt = 1'b0;
    // Counts assume everything queued, no waits; extra clocks are the
    // execution unit's business, so only the minimum is reported
    // Handshake slack and misaligned words add clocks the EU must absorb
    // No jump or call in this group, so no destination fetch is added
    case (queueByte0)
      `DTD_OP_LOAD_SEG: begin
        kindNxt = `DTD_K_LOAD_SEG;
        cyclesNxt = pickCount(isMem, wideBus, `DTD_C_LSEG_REG,
                              `DTD_C_LSEG_MEM_W, `DTD_C_LSEG_MEM_N);
      end
      `DTD_OP_STORE_SEG: begin
        kindNxt = `DTD_K_STORE_SEG;
        cyclesNxt = pickCount(isMem, wideBus, `DTD_C_SSEG_REG,
                              `DTD_C_SSEG_MEM_W, `DTD_C_SSEG_MEM_N);
      end
      `DTD_OP_TRANSLATE: begin
        kindNxt = `DTD_K_TABLE;
        cyclesNxt = wideBus ? `DTD_C_TABLE_W : `DTD_C_TABLE_N;
      end
      `DTD_OP_LDEA: begin
        kindNxt = `DTD_K_LDEA;
        cyclesNxt = `DTD_C_LDEA;
      end
      `DTD_OP_LFP_DATA: begin
        kindNxt = `DTD_K_LFP_DATA;
        cyclesNxt = wideBus ? `DTD_C_LFP_W : `DTD_C_LFP_N;
        illegalNxt = !isMem;
      end
      `DTD_OP_LFP_EXTRA: begin
        kindNxt = `DTD_K_LFP_EXTRA;
        cyclesNxt = wideBus ? `DTD_C_LFP_W : `DTD_C_LFP_N;
        illegalNxt = !isMem;
      end
      `DTD_OP_FL2AH: begin
        kindNxt = `DTD_K_FL2AH;
        cyclesNxt = `DTD_C_FL2AH;
      end
      `DTD_OP_AH2FL: begin
        kindNxt = `DTD_K_AH2FL;
        cyclesNxt = `DTD_C_AH2FL;
      end
      default: begin
        kindNxt = `DTD_K_NONE;
        cyclesNxt = 7'h00;
      end
    endcase
  end

  // ==========================================
  // Registered outputs
  // Decode advances when the execution unit takes it or no valid result is held, so a stalled
  // consumer holds the result steady
  always @(posedge clk) begin
    if (!reset_n) begin
      decodeValid_r <= 1'b0;
      opKind_r <= `DTD_K_NONE;
      minCycles_r <= 7'h00;
      memOperand_r <= 1'b0;
      wordSize_r <= 1'b0;
      modField_r <= 2'h0;
      regField_r <= 3'h0;
      rmField_r <= 3'h0;
      illegalForm_r <= 1'b0;
      consumeBytes_r <= 2'h0;
      decodeStall_r <= 1'b0;
      queueDepth_r <= `DTD_Q_NARROW;
    end else begin
      // Queue depth by variant: six bytes wide, four narrow
      queueDepth_r <= wideBus ? `DTD_Q_WIDE : `DTD_Q_NARROW;
      if (execReady || !decodeValid_r) begin
        decodeValid_r <= haveBytes;
        decodeStall_r <= !haveBytes;
        opKind_r <= kindNxt;
        minCycles_r <= cyclesNxt;
        memOperand_r <= needsModrm && isMem;
        wordSize_r <= queueByte0[0];
        modField_r <= needsModrm ? queueByte1[`DTD_MOD_HI:`DTD_MOD_LO] : 2'h0;
        regField_r <= needsModrm ? queueByte1[`DTD_REG_HI:`DTD_REG_LO] : 3'h0;
        rmField_r <= needsModrm ? queueByte1[`DTD_RM_HI:`DTD_RM_LO] : 3'h0;
        illegalForm_r <= illegalNxt;
        consumeBytes_r <= haveBytes ? bytesNeeded[1:0] : 2'h0;
      end
    end
  end

endmodule

// ---- dtd_decoder_chk.sv ----
`timescale 1ns/100ps
// ====================
// Decode checks
module dtd_decoder_chk (
  // Inputs
  input wire clk,
  input wire reset_n,
  input wire wideBus,
  input wire execReady,
  input wire [3:0] queueCount,
  input wire [7:0] queueByte0,
  input wire [7:0] queueByte1,
  // Results
  input wire decodeValid_r,
  input wire decodeStall_r,
  input wire illegalForm_r,
  input wire [6:0] minCycles_r,
  input wire [1:0] modField_r,
  input wire [2:0] regField_r,
  input wire [2:0] rmField_r
);
  logic tk_r, w_r;
  logic [7:0] op_r, ab_r;
  logic [3:0] n_r;
  wire full = tk_r && n_r > 4'h1;
  wire mem = ab_r[7:6] != 2'h3;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Inputs of the last edge and whether it was taken, as results lag one cycle
  always @(posedge clk) begin
    tk_r <= reset_n && (execReady || !decodeValid_r);
    w_r <= wideBus;
    op_r <= queueByte0;
    ab_r <= queueByte1;
    n_r <= queueCount;
  end
  AST_HOLD: assert property (decodeValid_r && !execReady |=> $stable(minCycles_r))
    else $error("held result moved");
  AST_TABLE_TRANSLATE_OP: assert property (tk_r && n_r > 4'h0 && op_r == 8'hD7 |->
    minCycles_r == (w_r ? 7'h0B : 7'h0F)) else $error("translate count");
  AST_SEGLD: assert property (full && op_r == 8'h8E |->
    minCycles_r == (!mem ? 7'h02 : w_r ? 7'h09 : 7'h0D)) else $error("seg load count");
  AST_SEGST: assert property (full && op_r == 8'h8C |->
    minCycles_r == (!mem ? 7'h02 : w_r ? 7'h0B : 7'h0F)) else $error("seg store count");
  AST_LFP: assert property (full && op_r[7:1] == 7'h62 |->
    minCycles_r == (w_r ? 7'h12 : 7'h1A) && illegalForm_r == !mem) else $error("far count");
  AST_LDEA: assert property (full && op_r == 8'h8D |->
    minCycles_r == 7'h06 && {modField_r, regField_r, rmField_r} == ab_r) else $error("ea");
  AST_FLAGS: assert property (tk_r && n_r > 4'h0 && op_r[7:1] == 7'h4F |->
    minCycles_r == (op_r[0] ? 7'h02 : 7'h03)) else $error("flag move count");
  AST_STALL: assert property (tk_r && n_r < 4'h2 && op_r == 8'h8D |->
    decodeStall_r && !decodeValid_r) else $error("no stall");
endmodule
bind dtd_decoder dtd_decoder_chk CHK (.*);

// ---- dtd_decoder_tb_top.sv ----
`timescale 1ns/100ps
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin miscompares++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
// ====================
// Decoder bench
module dtd_decoder_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wideBus = 1'b1;
  logic execReady = 1'b1;
  logic [3:0] cnt = 4'h0;
  logic [7:0] b0 = 8'h00;
  logic [7:0] b1 = 8'h00;
  int miscompares = 0;
  int nCompared = 0;
  int cyc = 0;
  wire [3:0] queueCount, opKind_r, queueDepth_r;
  wire [7:0] queueByte0, queueByte1;
  wire [6:0] minCycles_r;
  wire [1:0] modField_r, consumeBytes_r;
  wire [2:0] regField_r, rmField_r;
  wire decodeValid_r, memOperand_r, wordSize_r, illegalForm_r, decodeStall_r;
  dtd_queue_model QM (.*);
  dtd_decoder DUT (.*);
  // Clock, with a cycle ceiling against hangs
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      testDone;
    end
  end
  // Queue one head, let one edge take it, judge at the next falling edge
  task automatic dec(input [3:0] c, input [7:0] o, input [7:0] a, input w, input [3:0] k,
      input [6:0] m);
    @(posedge clk);
    cnt <= c;
    b0 <= o;
    b1 <= a;
    @(negedge clk);
    wideBus = w;
    @(negedge clk);
    `CHK(opKind_r, k)
    `CHK(minCycles_r, m)
    `CHK(queueDepth_r, w ? 4'h6 : 4'h4)
    `CHK({decodeValid_r, consumeBytes_r}, {1'b1, c[1:0]})
  endtask
  // Every opcode on both variants; register and memory forms of the segment moves, one form of the others
  task automatic tOps;
    for (int w = 0; w < 2; w++) begin
      dec(4'h2, 8'h8E, 8'hC0, w[0], 4'h1, 7'h02);
      dec(4'h2, 8'h8E, 8'h06, w[0], 4'h1, w ? 7'h09 : 7'h0D);
      dec(4'h2, 8'h8C, 8'hD8, w[0], 4'h2, 7'h02);
      dec(4'h2, 8'h8C, 8'h47, w[0], 4'h2, w ? 7'h0B : 7'h0F);
      `CHK(memOperand_r, 1'b1)
      dec(4'h1, 8'h90, 8'h00, w[0], 4'h0, 7'h00);
      dec(4'h1, 8'hD7, 8'h00, w[0], 4'h3, w ? 7'h0B : 7'h0F);
      dec(4'h2, 8'h8D, 8'h5E, w[0], 4'h4, 7'h06);
      `CHK({modField_r, regField_r, rmField_r, wordSize_r}, 9'h0BD)
      dec(4'h2, 8'hC5, 8'h06, w[0], 4'h5, w ? 7'h12 : 7'h1A);
      dec(4'h2, 8'hC4, 8'hC0, w[0], 4'h6, w ? 7'h12 : 7'h1A);
      `CHK(illegalForm_r, 1'b1)
      dec(4'h1, 8'h9F, 8'h00, w[0], 4'h7, 7'h02);
      dec(4'h1, 8'h9E, 8'h00, w[0], 4'h8, 7'h03);
    end
  endtask
  // Short queue stalls; a busy execution unit freezes the result
  task automatic tStall;
    dec(4'h1, 8'h9E, 8'h00, 1'b1, 4'h8, 7'h03);
    cnt <= 4'h1;
    b0 <= 8'h8D;
    @(negedge clk);
    @(negedge clk);
    `CHK({decodeValid_r, decodeStall_r}, 2'h1)
    dec(4'h1, 8'h9F, 8'h00, 1'b1, 4'h7, 7'h02);
    execReady = 1'b0;
    dec(4'h1, 8'hD7, 8'h00, 1'b1, 4'h7, 7'h02);
    execReady = 1'b1;
  endtask
  // Verdict
  task automatic testDone;
    $display("compared %0d miscompares %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    tOps;
    tStall;
    testDone;
  end
endmodule

// ---- dtd_queue_model.sv ----
`timescale 1ns/100ps
// ====================
// Prefetch queue head
module dtd_queue_model (
  // Fill request
  input wire clk,
  input wire [3:0] cnt,
  input wire [7:0] b0,
  input wire [7:0] b1,
  // Queue head
  output logic [3:0] queueCount = 4'h0,
  output logic [7:0] queueByte0 = 8'h00,
  output logic [7:0] queueByte1 = 8'h00
);
  // Empty slots toggle so a stale byte never looks queued
  always @(negedge clk) begin
    queueCount <= cnt;
    queueByte0 <= (cnt > 4'h0) ? b0 : ~queueByte0;
    queueByte1 <= (cnt > 4'h1) ? b1 : ~queueByte1;
  end
endmodule
